// ### hw/pid_defs.svh
// Purpose: word offsets and constants of the loop parameter block
// Assumes: 16-bit words, float values span two words, high word first
// Notes: definitions only
`ifndef PID_DEFS_SVH
`define PID_DEFS_SVH

// Parameter and input words
`define PID_W_GAIN 6'h01
`define PID_W_PWEIGHT 6'h03
`define PID_W_INTEG 6'h05
`define PID_W_DERIV 6'h07
`define PID_W_SP_F 6'h09
`define PID_W_CTRL 6'h0b
`define PID_W_MAN_F 6'h0c
`define PID_W_HI 6'h0e
`define PID_W_LO 6'h10
`define PID_W_MAN_X 6'h12
`define PID_W_SP_X 6'h13
// Start of the working area that is cleared
`define PID_W_CLR_LO 6'h14
`define PID_W_ACT_X 6'h15
`define PID_W_ACT_F 6'h16
`define PID_W_DIST_X 6'h18
`define PID_W_DIST_F 6'h19
`define PID_W_DIST_P 6'h1b
`define PID_W_DZ_X 6'h1d
`define PID_W_DZ_F 6'h1e
`define PID_W_DZ_P 6'h20
`define PID_W_DZD_P 6'h22
`define PID_W_DER 6'h24
`define PID_W_DEV_P 6'h26
`define PID_W_DEVD_P 6'h28
`define PID_W_RSV42 6'h2a
`define PID_W_YU_P 6'h2c
`define PID_W_YA_F 6'h2e
`define PID_W_YA_X 6'h30
`define PID_W_LAST 6'h30
`define PID_W_RSV0 6'h00
// Length a reusable working field must have
`define PID_FIELD_LEN 8'h30
// Fraction limits, just under plus and minus one
`define PID_FRAC_MAX 16'h7fff
`define PID_FRAC_MIN 16'h8001
`define PID_FLT_FRAC_MAX 32'sh0000_fffe
// Samples of the exponential approach to the manual value
`define PID_RAMP_STEPS 4
`endif

// ### hw/pid_pkg.sv
// Purpose: types shared by the loop parameter block
// Assumes: float words are signed 16.16 fixed point
// Notes: bits 15..8 of the control word carry nothing
package pid_pkg;
  typedef logic signed [31:0] pid_f_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALC = 2'b01,
    ST_DONE = 2'b11,
    ST_HALT = 2'b10
  } pid_state_t;
  typedef struct packed {
    logic [7:0] unused;
    logic process_float_select;
    logic setpoint_float_select;
    logic no_feed_forward;
    logic manual_hold_select;
    logic incremental_algorithm_select;
    logic controller_off_clear;
    logic derivative_source_select;
    logic auto_mode;
  } pid_ctrl_t;
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [5:0] addr;
    logic [15:0] wdata;
  } pid_req_t;
endpackage

// ### hw/pid_block.sv
// Purpose: one sampled PID step working on a word-addressed parameter block
// Assumes: caller fills inputs between calls; float words are 16.16 fixed point
// Notes: sums wrap on overflow; keep gains so results stay inside +-32768
`include "pid_defs.svh"
`timescale 1ns/10ps

module pid_block import pid_pkg::*; #(
  parameter int RAMP_STEPS = `PID_RAMP_STEPS
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire pid_req_t req_in,
  input wire logic controller_init_call_in,
  input wire logic [7:0] field_len_in,
  input wire logic controller_step_call_in,
  output logic [15:0] rdata_out,
  output logic rvalid_out,
  output logic busy_out,
  output logic done_out,
  output logic halted_out
);

  // Ramp counter is four bits wide
  if (RAMP_STEPS < 1 || RAMP_STEPS > 15) begin : g_bad_ramp
    $error("RAMP_STEPS must lie in 1..15");
  end

  logic [15:0] mem_q [0:`PID_W_LAST];
  logic [15:0] mem_d [0:`PID_W_LAST];
  pid_state_t state_q;
  pid_state_t state_d;
  logic [15:0] rdata_q;
  logic rvalid_q;
  logic busy_q;
  logic done_q;
  logic halted_q;
  logic off_done_q;
  logic auto_prev_q;
  logic [3:0] ramp_cnt_q;
  logic [3:0] ramp_cnt;
  logic host_wr;
  logic init_ok;
  pid_ctrl_t ctl;
  pid_f_t k, r, ti, td, hi, lo, sp, yh, act, z, xz;
  pid_f_t z_p, xz_p, pzd_p, der_p, dev_p, pwd_p, yu_p, ya_p;
  pid_f_t xw, pw, pz, qu, dd, di, dy, dz, incr, y_auto, y_man, y_unl, ya;
  logic at_lim;

  // Float word pair, high word first
  function automatic pid_f_t rd_f(input logic [5:0] idx);
    return {mem_q[idx], mem_q[idx + 6'h01]};
  endfunction

  // Fraction to 16.16: scale by two, sign carried up
  // fraction scaling
  function automatic pid_f_t frac2f(input logic [15:0] x);
    return {{15{x[15]}}, x, 1'b0};
  endfunction

  // 16.16 to fraction, saturated just inside plus and minus one
  function automatic logic [15:0] f2frac(input pid_f_t f);
    pid_f_t sh;
    sh = f >>> 1;
    if (f > `PID_FLT_FRAC_MAX) begin
      return `PID_FRAC_MAX;
    end else if (f < -`PID_FLT_FRAC_MAX) begin
      return `PID_FRAC_MIN;
    end else begin
      return sh[15:0];
    end
  endfunction

  function automatic pid_f_t fmul(input pid_f_t a, input pid_f_t b);
    logic signed [63:0] p;
    p = a * b;
    return p[47:16];
  endfunction

  function automatic pid_f_t clamp(input pid_f_t v, input pid_f_t l, input pid_f_t h);
    if (v > h) begin
      return h;
    end else if (v < l) begin
      return l;
    end else begin
      return v;
    end
  endfunction

  // Reserved words read zero and take no writes
  function automatic logic is_rsvd(input logic [5:0] a);
    return a == `PID_W_RSV0 || a == `PID_W_CLR_LO || a == `PID_W_RSV42 ||
      a == (`PID_W_RSV42 + 6'h01) || a > `PID_W_LAST;
  endfunction

  // Output words belong to the loop
  function automatic logic is_ro(input logic [5:0] a);
    return a >= `PID_W_YA_F && a <= `PID_W_LAST;
  endfunction

  // Operand fetch with format selection
  always_comb begin
    ctl = pid_ctrl_t'(mem_q[`PID_W_CTRL]);
    k = rd_f(`PID_W_GAIN);
    r = rd_f(`PID_W_PWEIGHT);
    ti = rd_f(`PID_W_INTEG);
    td = rd_f(`PID_W_DERIV);
    hi = rd_f(`PID_W_HI);
    lo = rd_f(`PID_W_LO);
    sp = ctl.setpoint_float_select ? rd_f(`PID_W_SP_F) : frac2f(mem_q[`PID_W_SP_X]);
    yh = ctl.setpoint_float_select ? rd_f(`PID_W_MAN_F) : frac2f(mem_q[`PID_W_MAN_X]);
    // actual value format, for all three
    act = ctl.process_float_select ? rd_f(`PID_W_ACT_F) : frac2f(mem_q[`PID_W_ACT_X]);
    z = ctl.process_float_select ? rd_f(`PID_W_DIST_F) : frac2f(mem_q[`PID_W_DIST_X]);
    xz = ctl.process_float_select ? rd_f(`PID_W_DZ_F) : frac2f(mem_q[`PID_W_DZ_X]);
    z_p = rd_f(`PID_W_DIST_P);
    xz_p = rd_f(`PID_W_DZ_P);
    pzd_p = rd_f(`PID_W_DZD_P);
    der_p = rd_f(`PID_W_DER);
    dev_p = rd_f(`PID_W_DEV_P);
    pwd_p = rd_f(`PID_W_DEVD_P);
    yu_p = rd_f(`PID_W_YU_P);
    ya_p = rd_f(`PID_W_YA_F);
  end

  // Step arithmetic, one sample per call
  always_comb begin
    xw = sp - act;
    pw = xw - dev_p;
    pz = xz - xz_p;
    qu = ctl.derivative_source_select ? pz - pzd_p : pw - pwd_p;
    dd = (fmul(td, qu) + der_p) >>> 1;
    at_lim = yu_p >= hi || yu_p <= lo;
    di = at_lim ? '0 : fmul(ti, xw);
    dy = fmul(k, fmul(pw, r) + di + dd);
    dz = ctl.no_feed_forward ? '0 : z - z_p;
    incr = dy + dz;
    y_auto = ctl.incremental_algorithm_select ? incr : yu_p + incr;
    ramp_cnt = auto_prev_q ? 4'h0 : ramp_cnt_q;
    if (ctl.manual_hold_select) begin
      y_man = ctl.incremental_algorithm_select ? '0 : ya_p;
    end else if (ctl.incremental_algorithm_select ||
        ramp_cnt >= 4'(RAMP_STEPS - 1)) begin
      y_man = yh;
    end else begin
      // Halve the gap each sample; last ramp sample lands exactly
      y_man = ya_p + ((yh - ya_p) >>> 1);
    end
    y_unl = ctl.auto_mode ? y_auto : y_man;
    // clamp to limits, also in manual
    ya = clamp(y_unl, lo, hi);
  end

  // Host writes only in the idle state, so a step sees stable inputs
  assign host_wr = req_in.wr_en && state_q == ST_IDLE && !is_rsvd(req_in.addr) &&
    !is_ro(req_in.addr);
  assign init_ok = field_len_in == `PID_FIELD_LEN;

  // Next contents of the block
  always_comb begin
    for (int i = 0; i <= int'(`PID_W_LAST); i++) begin
      mem_d[i] = mem_q[i];
    end
    if (host_wr) begin
      mem_d[req_in.addr] = req_in.wdata;
    end
    if (state_q == ST_IDLE && controller_init_call_in && init_ok) begin
      for (int i = int'(`PID_W_CLR_LO); i <= int'(`PID_W_LAST); i++) begin
        mem_d[i] = '0;
      end
    end
    if (state_q == ST_CALC) begin
      if (ctl.controller_off_clear) begin
        // clear once, then keep disturbance history
        if (!off_done_q) begin
          for (int i = int'(`PID_W_CLR_LO); i <= int'(`PID_W_LAST); i++) begin
            mem_d[i] = '0;
          end
        end
        {mem_d[`PID_W_DIST_P], mem_d[`PID_W_DIST_P + 6'h01]} = z;
      end else begin
        // output in both formats, word pair layout
        {mem_d[`PID_W_YA_F], mem_d[`PID_W_YA_F + 6'h01]} = ya;
        mem_d[`PID_W_YA_X] = f2frac(ya);
        {mem_d[`PID_W_YU_P], mem_d[`PID_W_YU_P + 6'h01]} = y_unl;
        {mem_d[`PID_W_DEV_P], mem_d[`PID_W_DEV_P + 6'h01]} = xw;
        {mem_d[`PID_W_DEVD_P], mem_d[`PID_W_DEVD_P + 6'h01]} = pw;
        {mem_d[`PID_W_DER], mem_d[`PID_W_DER + 6'h01]} = ctl.auto_mode ? dd : '0;
        if (ctl.derivative_source_select) begin
          {mem_d[`PID_W_DZ_P], mem_d[`PID_W_DZ_P + 6'h01]} = xz;
          {mem_d[`PID_W_DZD_P], mem_d[`PID_W_DZD_P + 6'h01]} = pz;
        end
        // disturbance history unless feed-forward is off in manual
        if (ctl.auto_mode || !ctl.no_feed_forward) begin
          {mem_d[`PID_W_DIST_P], mem_d[`PID_W_DIST_P + 6'h01]} = z;
        end
      end
    end
  end

  // Block storage; contents start cleared
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      for (int i = 0; i <= int'(`PID_W_LAST); i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i <= int'(`PID_W_LAST); i++) begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // Sequencer: idle, compute, report; a bad field halts for good
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (controller_init_call_in && !init_ok) begin
          state_d = ST_HALT;
        end else if (controller_step_call_in && !controller_init_call_in) begin
          state_d = ST_CALC;
        end
      end
      ST_CALC: begin
        state_d = ST_DONE;
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      ST_HALT: begin
        state_d = ST_HALT;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Status flags
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      halted_q <= 1'b0;
    end else begin
      busy_q <= state_d == ST_CALC || state_d == ST_DONE;
      done_q <= state_q == ST_CALC;
      halted_q <= state_d == ST_HALT;
    end
  end

  // Mode memory: one clear per off period, ramp count after a change to manual
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      off_done_q <= 1'b0;
      auto_prev_q <= 1'b1;
      ramp_cnt_q <= '0;
    end else if (state_q == ST_CALC) begin
      off_done_q <= ctl.controller_off_clear;
      auto_prev_q <= ctl.auto_mode;
      if (ctl.auto_mode) begin
        ramp_cnt_q <= '0;
      end else if (ramp_cnt < 4'(RAMP_STEPS)) begin
        ramp_cnt_q <= ramp_cnt + 4'h1;
      end else begin
        ramp_cnt_q <= ramp_cnt;
      end
    end
  end

  // Read port, one cycle latency; reads are served in every state
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req_in.rd_en;
      if (req_in.rd_en) begin
        rdata_q <= is_rsvd(req_in.addr) ? 16'h0000 : mem_q[req_in.addr];
      end
    end
  end

  assign rdata_out = rdata_q;
  assign rvalid_out = rvalid_q;
  assign busy_out = busy_q;
  assign done_out = done_q;
  assign halted_out = halted_q;

  // Checks
  sequence seq_step_run;
    state_q == ST_CALC ##1 done_q;
  endsequence
  sequence seq_calc_on;
    state_q == ST_CALC && !ctl.controller_off_clear;
  endsequence
  step_done_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    state_q == ST_IDLE && controller_step_call_in && !controller_init_call_in
    |=> seq_step_run) else $error("step did not complete in two cycles");
  out_clamp_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    seq_calc_on |=> rd_f(`PID_W_YA_F) <= rd_f(`PID_W_HI) &&
    rd_f(`PID_W_YA_F) >= rd_f(`PID_W_LO)) else $error("output outside limits");
  out_frac_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    seq_calc_on |=> mem_q[`PID_W_YA_X] == f2frac(rd_f(`PID_W_YA_F)))
    else $error("fraction output disagrees with float output");
  off_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    state_q == ST_CALC && ctl.controller_off_clear && !off_done_q
    |=> rd_f(`PID_W_YA_F) == 0 && rd_f(`PID_W_DEV_P) == 0 && mem_q[`PID_W_YA_X] == 0)
    else $error("controller off did not clear working area");
  off_dist_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    state_q == ST_CALC && ctl.controller_off_clear
    |=> rd_f(`PID_W_DIST_P) == $past(z)) else $error("disturbance history not updated");
  man_deriv_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    seq_calc_on ##0 (!ctl.auto_mode) |=> rd_f(`PID_W_DER) == 0)
    else $error("derivative term not zeroed in manual");
  hold_pos_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    seq_calc_on ##0 (!ctl.auto_mode && ctl.manual_hold_select &&
    !ctl.incremental_algorithm_select && $past(state_q) == ST_IDLE)
    |=> rd_f(`PID_W_YA_F) == clamp($past(ya_p), lo, hi)) else $error("held output moved");
  hold_vel_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    seq_calc_on ##0 (!ctl.auto_mode && ctl.manual_hold_select &&
    ctl.incremental_algorithm_select) |=> rd_f(`PID_W_YA_F) == clamp(0, lo, hi))
    else $error("held increment not zero");
  init_halt_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    state_q == ST_IDLE && controller_init_call_in && !init_ok
    |=> halted_out [*3]) else $error("bad field length did not halt");
  init_clear_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    state_q == ST_IDLE && controller_init_call_in && init_ok
    |=> mem_q[`PID_W_YA_X] == 0 && rd_f(`PID_W_YU_P) == 0 && !halted_out)
    else $error("init reuse did not clear working area");
endmodule

// ### verif/pid_prog.sv
// Purpose: user program model that fills, steps and reads the parameter block
// Assumes: one request per access, driven on the falling clock edge
// Notes: released address, data and length lines show inverted last values and strobes drop low, so stale data never looks valid
`timescale 1ns/10ps

module pid_prog import pid_pkg::*; (
  input wire logic clk_in,
  output pid_req_t req_out,
  output logic init_out,
  output logic [7:0] len_out,
  output logic step_out
);
  // Quiet bus from time zero
  initial begin
    req_out = '0;
    init_out = 1'b0;
    len_out = 8'h00;
    step_out = 1'b0;
  end

  // One word access held for one edge, then released to a changed pattern
  task automatic access(input logic wr, input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_in);
    req_out = '{wr, !wr, a, d};
    @(negedge clk_in);
    req_out = '{1'b0, 1'b0, ~a, ~d};
  endtask

  // float is two words, high first
  task automatic wr_float(input logic [5:0] a, input logic [31:0] v);
    access(1'b1, a, v[31:16]);
    access(1'b1, a + 6'h01, v[15:0]);
  endtask

  // sign-magnitude to two's complement, minus zero as zero
  task automatic wr_frac(input logic [5:0] a, input logic [15:0] sm);
    access(1'b1, a, sm[15] ? ~{1'b0, sm[14:0]} + 16'h0001 : sm);
  endtask

  // one block per loop, field length handed with the call
  task automatic call_init(input logic [7:0] len);
    @(negedge clk_in);
    init_out = 1'b1;
    len_out = len;
    @(negedge clk_in);
    init_out = 1'b0;
    len_out = ~len;
  endtask

  // one step per sample; again keeps the request up into busy
  task automatic call_step(input logic again);
    @(negedge clk_in);
    step_out = 1'b1;
    @(negedge clk_in);
    step_out = again;
    @(negedge clk_in);
    step_out = 1'b0;
  endtask
endmodule

// ### verif/test_pid_block.sv
// Purpose: self-checking bench for the loop parameter block
// Assumes: 16.16 float words, fractions doubled when converted
// Notes: reads are scored against a queue of notes in request order
`timescale 1ns/10ps

module test_pid_block import pid_pkg::*; ;
  logic clk_in;
  logic arst_n_in;
  pid_req_t req;
  logic init_c;
  logic step_c;
  logic [7:0] len;
  logic [15:0] rdata;
  logic rvalid;
  logic busy;
  logic done;
  logic halted;
  logic [15:0] exp_q[$];
  int mismatches;
  int checked;
  logic [15:0] v;
  logic [5:0] ro[6] = '{6'h00, 6'h14, 6'h2a, 6'h2e, 6'h30, 6'h3f};
  logic [31:0] outs[7] = '{32'h0000_4000, 32'h0000_6000, 32'h0000_7000, 32'h0000_8000,
    32'h0000_0000, 32'h0000_c000, 32'hffff_4000};
  logic [15:0] mins[7] = '{16'h4000, 16'h4000, 16'h4000, 16'h4000, 16'h8000, 16'h7fff,
    16'hffff};
  logic [15:0] ctls[4] = '{16'h0010, 16'h0008, 16'h0018, 16'hff48};
  logic [31:0] mouts[4] = '{32'hffff_4000, 32'h0000_4000, 32'h0000_0000, 32'h0000_2000};

  pid_block #(.RAMP_STEPS(4)) dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .req_in(req),
    .controller_init_call_in(init_c), .field_len_in(len), .controller_step_call_in(step_c),
    .rdata_out(rdata), .rvalid_out(rvalid), .busy_out(busy), .done_out(done),
    .halted_out(halted));

  pid_prog prog (.clk_in(clk_in), .req_out(req), .init_out(init_c), .len_out(len),
    .step_out(step_c));

  // 20 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    prog.access(1'b0, a, 16'($urandom));
  endtask

  task automatic rdf(input logic [5:0] a, input logic [31:0] e);
    rd(a, e[31:16]);
    rd(a + 6'h01, e[15:0]);
  endtask

  // Busy and done follow the step request by fixed cycles
  task automatic step(input logic again);
    fork
      prog.call_step(again);
      begin
        repeat (2) @(negedge clk_in);
        check({14'h0000, busy, done}, 16'h0002);
        @(negedge clk_in);
        check({14'h0000, busy, done}, 16'h0003);
        @(negedge clk_in);
        check({14'h0000, busy, done}, 16'h0000);
      end
    join
  endtask

  task automatic test_end(input string name);
    repeat (3) @(negedge clk_in);
    $display("test %s finished", name);
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Score each read answer against the oldest note, mid-cycle where it has settled
  always @(negedge clk_in) begin
    if (rvalid === 1'b1) begin
      if (exp_q.size() > 0) begin
        check(rdata, exp_q.pop_front());
      end else begin
        check(rdata, ~rdata);
      end
    end
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(20000 * 50);
    mismatches++;
    test_done();
  end

  initial begin
    arst_n_in = 1'b0;
    v = 16'($urandom(25));
    repeat (8) @(negedge clk_in);
    arst_n_in = 1'b1;
    // Reset clears the whole block; unmapped words read zero
    for (int a = 0; a < 64; a += 7) rd(6'(a), 16'h0000);
    // Parameter words hold what was written; reserved and outputs refuse writes
    for (int a = 1; a < 20; a++) begin
      v = 16'($urandom);
      prog.access(1'b1, 6'(a), v);
      rd(6'(a), v);
    end
    foreach (ro[i]) begin
      prog.access(1'b1, ro[i], 16'hffff);
      rd(ro[i], 16'h0000);
    end
    test_end("registers");
    // Good-length init clears the working area and keeps the setpoint
    prog.access(1'b1, 6'h13, 16'h2000);
    prog.access(1'b1, 6'h15, 16'h1234);
    prog.call_init(8'h30);
    rd(6'h15, 16'h0000);
    rd(6'h13, 16'h2000);
    test_end("init");
    // Manual position: four-sample approach, then clamped follow
    prog.wr_float(6'h0e, 32'h0000_c000);
    prog.wr_float(6'h10, 32'hffff_4000);
    prog.access(1'b1, 6'h0b, 16'h0000);
    foreach (outs[i]) begin
      prog.wr_frac(6'h12, mins[i]);
      step(i == 0);
      rdf(6'h2e, outs[i]);
      rd(6'h30, outs[i][16:1]);
    end
    // Hold, velocity pass, zero increment, float manual with junk high bits
    prog.wr_float(6'h0c, 32'h0000_2000);
    prog.wr_frac(6'h12, 16'h2000);
    foreach (ctls[i]) begin
      prog.access(1'b1, 6'h0b, ctls[i]);
      step(1'b0);
      rdf(6'h2e, mouts[i]);
    end
    test_end("manual");
    // Off clears once, keeps setpoint, still tracks the disturbance
    prog.access(1'b1, 6'h0b, 16'h0004);
    prog.access(1'b1, 6'h15, 16'h1111);
    step(1'b0);
    rd(6'h15, 16'h0000);
    rdf(6'h2e, 32'h0000_0000);
    rd(6'h13, 16'h2000);
    prog.access(1'b1, 6'h15, 16'h1111);
    prog.access(1'b1, 6'h18, 16'h1000);
    step(1'b0);
    rd(6'h15, 16'h1111);
    rdf(6'h1b, 32'h0000_2000);
    test_end("off");
    // Pure P step from a cleared history, both gain signs
    prog.wr_float(6'h03, 32'h0001_0000);
    prog.wr_float(6'h05, 32'h0000_0000);
    prog.wr_float(6'h07, 32'h0000_0000);
    prog.access(1'b1, 6'h15, 16'h0000);
    for (int s = 0; s < 2; s++) begin
      prog.access(1'b1, 6'h0b, 16'h0004);
      step(1'b0);
      prog.wr_float(6'h01, s == 0 ? 32'h0001_0000 : 32'hffff_0000);
      prog.access(1'b1, 6'h0b, 16'h0021);
      step(1'b0);
      rdf(6'h2e, s == 0 ? 32'h0000_4000 : 32'hffff_c000);
      rd(6'h30, s == 0 ? 16'h2000 : 16'he000);
      rdf(6'h26, 32'h0000_4000);
    end
    test_end("auto");
    // Float process inputs, auxiliary derivative and feed-forward from a cleared field
    prog.access(1'b1, 6'h0b, 16'h0004);
    step(1'b0);
    prog.wr_float(6'h01, 32'h0001_0000);
    prog.wr_float(6'h05, 32'h0000_4000);
    prog.wr_float(6'h07, 32'h0001_0000);
    prog.wr_float(6'h16, 32'h0000_2000);
    prog.wr_float(6'h1e, 32'h0000_1000);
    prog.wr_float(6'h19, 32'h0000_0800);
    prog.access(1'b1, 6'h0b, 16'h0083);
    step(1'b0);
    // P 0.125, I 0.03125, D 0.03125, feed-forward 0.03125
    rdf(6'h2e, 32'h0000_3800);
    rd(6'h30, 16'h1c00);
    rdf(6'h24, 32'h0000_0800);
    rdf(6'h20, 32'h0000_1000);
    rdf(6'h1b, 32'h0000_0800);
    // Previous output sits on the new upper limit, so the integral part is dropped
    prog.wr_float(6'h0e, 32'h0000_3800);
    step(1'b0);
    rdf(6'h2e, 32'h0000_3400);
    test_end("float");
    // Wrong field length halts; writes refused until reset
    prog.call_init(8'($urandom) | 8'h40);
    check({15'h0000, halted}, 16'h0001);
    prog.access(1'b1, 6'h01, 16'h1234);
    rd(6'h01, 16'h0001);
    // Let the last read answer be scored before reset clears it
    @(negedge clk_in);
    arst_n_in = 1'b0;
    repeat (8) @(negedge clk_in);
    arst_n_in = 1'b1;
    check({15'h0000, halted}, 16'h0000);
    rd(6'h01, 16'h0000);
    test_end("halt");
    test_done();
  end
endmodule
